// ---- inc/proto_map.svh ----
// Offsets, field positions, reset values and characters of the option handler.
// Contract
// [R1] Address-always bit prefixes own address to every data reply, global ones too.
// [R2] Acknowledge bit answers every command; a data reply is its own acknowledgement.
// [R3] Percent is sent when the command was accepted and already executed.
// [R4] Asterisk is sent when the command was accepted and queued.
// [R5] Question mark is sent on a parse error, optionally followed by an error code.
// [R6] Error codes run from 1 to 14.
// [R7] Acknowledge characters always go out of the RS-232 port.
// [R8] On RS-485 an acknowledge goes out only for addressed commands.
// [R9] On RS-485 global commands without data request get no acknowledge.
// [R10] Addressed commands get the address before acknowledge or error, on both ports.
// [R11] Global data requests make every drive reply; host should address commands.
// [R12] Checksum bit has no effect; nothing appended or checked.
// [R13] Adapter mode echoes tilde-led RS-232 commands out of both ports.
// [R14] The tilde is removed from the forwarded command.
// [R15] Without adapter mode addressed commands echo on RS-232 only.
// [R16] With adapter and acknowledge bits the echo precedes the reply.
// [R17] Numeric bit makes load and upload name registers by three digits 000 to 074.
// [R18] Register data replies name the register by its single character.
// [R19] Load with only a register number returns letters, character, equals, value.
// [R20] Upload returns count consecutive registers as separate ascending replies.
// [R21] Protocol setting is a six-bit word, each bit an independent option.
// [R22] Setting is never zero; default alone answers only data requests.
// [R23] Every reply packet and echo ends with a carriage return.
`ifndef PROTO_MAP_SVH
`define PROTO_MAP_SVH
`define OFS_PROTO  12'h000
`define OFS_ADDR   12'h004
`define OFS_STAT   12'h008
`define BIT_DEF    0
`define BIT_ADDR   1
`define BIT_ACK    2
`define BIT_CSUM   3
`define BIT_ADAPT  4
`define BIT_NUM    5
`define RST_PROTO  6'h01
`define RST_ADDR   8'h31
`define CH_ACK     8'h25
`define CH_QUE     8'h2a
`define CH_NAK     8'h3f
`define CH_TILDE   8'h7e
`define CH_EQ      8'h3d
`define CH_CR      8'h0d
`define CH_ZERO    8'h30
`define CH_ONE     8'h31
`define ADDR_LO    8'h21
`define ADDR_HI    8'h40
`define REG_MAX    10'h04a
`define ERR_RANGE  4'h5
`define ERR_TEN    4'ha
`endif

// ---- inc/proto_pkg.sv ----
// Types shared by the option handler modules.
package proto_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_ECHO = 4'h1, ST_WAIT = 4'h2, ST_PFX = 4'h3,
    ST_L0   = 4'h4, ST_L1   = 4'h5, ST_DES  = 4'h6, ST_EQ  = 4'h7,
    ST_VAL  = 4'h8, ST_ACK  = 4'h9, ST_E1   = 4'ha, ST_E2  = 4'hb,
    ST_CR   = 4'hc
  } state_t;
  typedef enum logic [2:0] {
    RK_DONE = 3'h0, RK_QUEUED = 3'h1, RK_NACK = 3'h2, RK_DATA = 3'h3,
    RK_LOAD = 3'h4, RK_UPLOAD = 3'h5, RK_SKIP = 3'h6
  } res_kind_t;
  typedef struct packed {
    state_t      st;
    state_t      ret;
    logic [5:0]  proto;
    logic [7:0]  addr;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rx_ready;
    logic        res_ready;
    logic        tx_valid;
    logic [7:0]  tx_char;
    logic        t232;
    logic        t485;
    logic        o232;
    logic        o485;
    logic        src485;
    logic        first;
    logic        addressed;
    res_kind_t   kind;
    logic [3:0]  err;
    logic [15:0] letters;
    logic [31:0] val;
    logic [7:0]  cnt;
    logic [6:0]  idx;
    logic        pfx;
    logic        dig_start;
    logic [7:0]  nacks;
  } handler_state_t;
  typedef struct packed {
    logic [3:0]  k;
    logic [31:0] rem;
    logic        run;
    logic        lead;
  } digit_state_t;
endpackage : proto_pkg

// ---- hdl/name_map.sv ----
// Register designation mapping between digits, characters and indices.
`timescale 1ns/1ns
`include "proto_map.svh"
module name_map (
  input  wire logic [23:0] reg_field,
  input  wire logic        numeric,
  input  wire logic [6:0]  idx_in,
  output logic      [6:0]  idx,
  output logic             in_range,
  output logic      [7:0]  des_char
);
  import proto_pkg::*;

  function automatic logic is_digit(input logic [7:0] c);
    return (c >= `CH_ZERO) && (c <= 8'h39);
  endfunction : is_digit

  logic [9:0] num;

  always_comb begin
    if (numeric) begin
      num = 10'(reg_field[23:16] - `CH_ZERO) * 10'd100 +
            10'(reg_field[15:8] - `CH_ZERO) * 10'd10 + 10'(reg_field[7:0] - `CH_ZERO); // [R17]
      in_range = is_digit(reg_field[23:16]) && is_digit(reg_field[15:8]) &&
                 is_digit(reg_field[7:0]) && (num <= `REG_MAX);
    end else begin
      num = {2'b00, reg_field[7:0] - `CH_ZERO};
      in_range = (reg_field[7:0] >= `CH_ZERO) && (num <= `REG_MAX);
    end
    idx = num[6:0];
    des_char = `CH_ZERO + {1'b0, idx_in}; // [R18]
  end
endmodule : name_map

// ---- hdl/dec_digits.sv ----
// Serial binary to decimal ASCII digit generator, most significant first.
`timescale 1ns/1ns
`include "proto_map.svh"
module dec_digits (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic [31:0] value,
  input  wire logic        next,
  output logic      [7:0]  dig,
  output logic             valid,
  output logic             last
);
  import proto_pkg::*;

  function automatic logic [31:0] pow10(input logic [3:0] k);
    case (k)
      4'h0: pow10 = 32'd1;
      4'h1: pow10 = 32'd10;
      4'h2: pow10 = 32'd100;
      4'h3: pow10 = 32'd1000;
      4'h4: pow10 = 32'd10000;
      4'h5: pow10 = 32'd100000;
      4'h6: pow10 = 32'd1000000;
      4'h7: pow10 = 32'd10000000;
      4'h8: pow10 = 32'd100000000;
      default: pow10 = 32'd1000000000;
    endcase
  endfunction : pow10

  digit_state_t cur_ff, nxt_ff;
  logic [3:0]   d;
  logic [35:0]  sub;

  always_comb begin
    nxt_ff = cur_ff;
    d = 4'h0;
    for (int j = 1; j < 10; j++) begin
      if ({4'h0, cur_ff.rem} >= 36'(j) * {4'h0, pow10(cur_ff.k)}) begin
        d = 4'(j);
      end
    end
    sub = {32'h0, d} * {4'h0, pow10(cur_ff.k)};
    valid = cur_ff.run && (cur_ff.lead || (d != 4'h0) || (cur_ff.k == 4'h0));
    last = cur_ff.k == 4'h0;
    dig = `CH_ZERO + {4'h0, d};
    if (start) begin
      nxt_ff.run = 1'b1;
      nxt_ff.k = 4'h9;
      nxt_ff.rem = value;
      nxt_ff.lead = 1'b0;
    end else if (cur_ff.run && (!valid || next)) begin
      nxt_ff.rem = cur_ff.rem - sub[31:0];
      nxt_ff.lead = cur_ff.lead || valid;
      if (last) begin
        nxt_ff.run = 1'b0;
      end else begin
        nxt_ff.k = cur_ff.k - 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
    end else if (ce) begin
      cur_ff <= nxt_ff;
    end
  end
endmodule : dec_digits

// ---- hdl/serial_protocol_option_handler.sv ----
// Reply formatting, acknowledge and echo logic of the serial command interpreter.
`timescale 1ns/1ns
`include "proto_map.svh"
module serial_protocol_option_handler (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                rx_valid,
  input  wire logic [7:0]          rx_char,
  input  wire logic                rx_port,
  input  wire logic                rx_last,
  output logic                     rx_ready,
  input  wire logic                res_valid,
  input  wire proto_pkg::res_kind_t res_kind,
  input  wire logic [3:0]          res_err,
  input  wire logic [15:0]         res_letters,
  input  wire logic [31:0]         res_value,
  input  wire logic [23:0]         res_reg,
  input  wire logic [7:0]          res_count,
  output logic                     res_ready,
  output logic      [6:0]          rd_idx,
  input  wire logic [31:0]         rd_data,
  output logic                     tx_valid,
  output logic      [7:0]          tx_char,
  output logic                     tx_to232,
  output logic                     tx_to485,
  input  wire logic                tx_ready
);
  import proto_pkg::*;

  // ----------------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------------
  function automatic logic is_addr(input logic [7:0] c);
    return (c >= `ADDR_LO) && (c <= `ADDR_HI);
  endfunction : is_addr

  function automatic logic is_data(input res_kind_t k);
    return (k == RK_DATA) || (k == RK_LOAD) || (k == RK_UPLOAD);
  endfunction : is_data

  function automatic logic mapped(input logic [11:0] a);
    return (a == `OFS_PROTO) || (a == `OFS_ADDR) || (a == `OFS_STAT);
  endfunction : mapped

  handler_state_t cur_ff, nxt_ff;
  logic           slot;
  logic           take_rx;
  logic           take_res;
  logic           dg_next;
  logic [7:0]     dg_char;
  logic           dg_valid;
  logic           dg_last;
  logic [6:0]     nm_idx;
  logic           nm_ok;
  logic [7:0]     nm_des;
  logic [5:0]     wproto;

  name_map u_name_map (
    .reg_field (res_reg),
    .numeric   (cur_ff.proto[`BIT_NUM]),
    .idx_in    (cur_ff.idx),
    .idx       (nm_idx),
    .in_range  (nm_ok),
    .des_char  (nm_des)
  );

  dec_digits u_dec_digits (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .start   (cur_ff.dig_start),
    .value   (cur_ff.val),
    .next    (dg_next),
    .dig     (dg_char),
    .valid   (dg_valid),
    .last    (dg_last)
  );

  always_comb begin
    nxt_ff = cur_ff;
    slot = !cur_ff.tx_valid || tx_ready;
    take_rx = rx_valid && cur_ff.rx_ready;
    take_res = res_valid && cur_ff.res_ready;
    dg_next = 1'b0;
    wproto = pwdata[5:0];
    nxt_ff.tx_valid = cur_ff.tx_valid && !tx_ready;
    nxt_ff.dig_start = 1'b0;

    // ----------------------------------------------------------------
    // APB slave with one wait state.
    // ----------------------------------------------------------------
    if (cur_ff.pready) begin
      nxt_ff.pready = 1'b0;
      nxt_ff.pslverr = 1'b0;
      if (psel && penable && pwrite) begin
        if (paddr == `OFS_PROTO) begin
          nxt_ff.proto = (wproto == 6'h00) ? `RST_PROTO : wproto; // [R21] [R22] [R12]
        end else if (paddr == `OFS_ADDR) begin
          nxt_ff.addr = pwdata[7:0];
        end
      end
    end else if (psel && penable) begin
      nxt_ff.pready = 1'b1;
      nxt_ff.pslverr = !mapped(paddr);
      nxt_ff.prdata = 32'h0;
      if (!pwrite && (paddr == `OFS_PROTO)) begin
        nxt_ff.prdata = {26'h0, cur_ff.proto};
      end else if (!pwrite && (paddr == `OFS_ADDR)) begin
        nxt_ff.prdata = {24'h0, cur_ff.addr};
      end else if (!pwrite && (paddr == `OFS_STAT)) begin
        nxt_ff.prdata = {16'h0, cur_ff.nacks, 4'h0, cur_ff.st};
      end
    end

    // ----------------------------------------------------------------
    // Echo and reply sequencer.
    // ----------------------------------------------------------------
    unique case (cur_ff.st)
      ST_IDLE: begin
        if (take_rx) begin
          nxt_ff.src485 = rx_port;
          nxt_ff.ret = ST_WAIT;
          if (!rx_port && (rx_char == `CH_TILDE) && cur_ff.proto[`BIT_ADAPT]) begin
            nxt_ff.o232 = 1'b1; // [R13]
            nxt_ff.o485 = 1'b1; // [R13]
            nxt_ff.first = 1'b1;
            nxt_ff.addressed = 1'b0;
            nxt_ff.st = rx_last ? ST_CR : ST_ECHO; // [R14]
          end else begin
            nxt_ff.first = 1'b0;
            nxt_ff.addressed = is_addr(rx_char);
            nxt_ff.o232 = is_addr(rx_char); // [R15]
            nxt_ff.o485 = 1'b0; // [R15]
            if (is_addr(rx_char)) begin
              nxt_ff.tx_valid = 1'b1;
              nxt_ff.tx_char = rx_char;
              nxt_ff.t232 = 1'b1;
              nxt_ff.t485 = 1'b0;
              nxt_ff.st = rx_last ? ST_CR : ST_ECHO;
            end else begin
              nxt_ff.st = rx_last ? ST_WAIT : ST_ECHO;
            end
          end
        end
      end
      ST_ECHO: begin
        if (take_rx) begin
          if (cur_ff.first) begin
            nxt_ff.first = 1'b0;
            nxt_ff.addressed = is_addr(rx_char);
          end
          if (cur_ff.o232 || cur_ff.o485) begin
            nxt_ff.tx_valid = 1'b1;
            nxt_ff.tx_char = rx_char;
            nxt_ff.t232 = cur_ff.o232;
            nxt_ff.t485 = cur_ff.o485;
          end
          if (rx_last) begin
            nxt_ff.st = (cur_ff.o232 || cur_ff.o485) ? ST_CR : ST_WAIT; // [R23]
          end
        end
      end
      ST_WAIT: begin
        if (take_res) begin // [R16]
          nxt_ff.kind = res_kind;
          nxt_ff.err = res_err;
          nxt_ff.letters = res_letters;
          nxt_ff.val = res_value;
          nxt_ff.idx = nm_idx; // [R17]
          nxt_ff.cnt = (res_count == 8'h00) ? 8'h01 : res_count;
          nxt_ff.ret = ST_IDLE;
          nxt_ff.o232 = 1'b1; // [R7]
          nxt_ff.o485 = cur_ff.addressed || (is_data(res_kind) && cur_ff.src485); // [R8] [R9] [R11]
          nxt_ff.pfx = cur_ff.addressed ||
                       (is_data(res_kind) && cur_ff.proto[`BIT_ADDR]); // [R1] [R10]
          if (((res_kind == RK_LOAD) || (res_kind == RK_UPLOAD)) && !nm_ok) begin
            nxt_ff.kind = RK_NACK;
            nxt_ff.err = `ERR_RANGE;
          end
          if (res_kind == RK_SKIP) begin
            nxt_ff.st = ST_IDLE;
          end else if (!is_data(res_kind) && !cur_ff.proto[`BIT_ACK]) begin
            nxt_ff.st = ST_IDLE; // [R22]
          end else if (((res_kind == RK_LOAD) || (res_kind == RK_UPLOAD)) && !nm_ok &&
                       !cur_ff.proto[`BIT_ACK]) begin
            nxt_ff.st = ST_IDLE;
          end else if (cur_ff.addressed || (is_data(res_kind) && cur_ff.proto[`BIT_ADDR])) begin
            nxt_ff.st = ST_PFX;
          end else begin
            nxt_ff.st = is_data(res_kind) && nm_ok ? ST_L0 : ST_ACK; // [R2]
          end
          if ((res_kind == RK_DATA) && !cur_ff.addressed && !cur_ff.proto[`BIT_ADDR]) begin
            nxt_ff.st = ST_L0;
          end
        end
      end
      ST_PFX: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = cur_ff.addr; // [R1] [R10]
          nxt_ff.t232 = cur_ff.o232;
          nxt_ff.t485 = cur_ff.o485;
          nxt_ff.st = is_data(cur_ff.kind) ? ST_L0 : ST_ACK;
        end
      end
      ST_L0: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = cur_ff.letters[15:8];
          nxt_ff.t232 = cur_ff.o232;
          nxt_ff.t485 = cur_ff.o485;
          nxt_ff.st = ST_L1;
        end
      end
      ST_L1: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = cur_ff.letters[7:0];
          nxt_ff.st = (cur_ff.kind == RK_DATA) ? ST_EQ : ST_DES; // [R19]
        end
      end
      ST_DES: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = nm_des; // [R18]
          nxt_ff.val = rd_data; // [R19]
          nxt_ff.st = ST_EQ;
        end
      end
      ST_EQ: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = `CH_EQ; // [R19]
          nxt_ff.dig_start = 1'b1;
          nxt_ff.st = ST_VAL;
        end
      end
      ST_VAL: begin
        if (slot && dg_valid && !cur_ff.dig_start) begin
          dg_next = 1'b1;
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = dg_char;
          if (dg_last) begin
            nxt_ff.st = ST_CR;
            if ((cur_ff.kind == RK_UPLOAD) && (cur_ff.cnt > 8'h01)) begin
              nxt_ff.cnt = cur_ff.cnt - 8'h01; // [R20]
              nxt_ff.idx = cur_ff.idx + 7'h01; // [R20]
              nxt_ff.ret = cur_ff.pfx ? ST_PFX : ST_L0; // [R20]
            end else begin
              nxt_ff.ret = ST_IDLE; // [R20]
            end
          end
        end
      end
      ST_ACK: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.t232 = cur_ff.o232; // [R7]
          nxt_ff.t485 = cur_ff.o485; // [R8] [R9]
          if (cur_ff.kind == RK_QUEUED) begin
            nxt_ff.tx_char = `CH_QUE; // [R4]
            nxt_ff.st = ST_CR;
          end else if (cur_ff.kind == RK_NACK) begin
            nxt_ff.tx_char = `CH_NAK; // [R5]
            nxt_ff.nacks = cur_ff.nacks + 8'h01;
            nxt_ff.st = (cur_ff.err != 4'h0) ? ST_E1 : ST_CR; // [R5]
          end else begin
            nxt_ff.tx_char = `CH_ACK; // [R3]
            nxt_ff.st = ST_CR;
          end
        end
      end
      ST_E1: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          if (cur_ff.err >= `ERR_TEN) begin
            nxt_ff.tx_char = `CH_ONE; // [R6]
            nxt_ff.st = ST_E2;
          end else begin
            nxt_ff.tx_char = `CH_ZERO + {4'h0, cur_ff.err}; // [R6]
            nxt_ff.st = ST_CR;
          end
        end
      end
      ST_E2: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = `CH_ZERO + {4'h0, cur_ff.err - `ERR_TEN}; // [R6]
          nxt_ff.st = ST_CR;
        end
      end
      ST_CR: begin
        if (slot) begin
          nxt_ff.tx_valid = 1'b1;
          nxt_ff.tx_char = `CH_CR; // [R23]
          nxt_ff.t232 = cur_ff.o232;
          nxt_ff.t485 = cur_ff.o485;
          nxt_ff.st = cur_ff.ret;
        end
      end
      default: begin
        nxt_ff.st = ST_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Input handshakes, receive ready only when the output slot is free, result ready in ST_WAIT only.
    // ----------------------------------------------------------------
    nxt_ff.rx_ready = ((nxt_ff.st == ST_IDLE) || (nxt_ff.st == ST_ECHO)) && !nxt_ff.tx_valid;
    nxt_ff.res_ready = (nxt_ff.st == ST_WAIT) && !take_res;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '{st: ST_IDLE, ret: ST_IDLE, proto: `RST_PROTO, addr: `RST_ADDR,
                  kind: RK_DONE, default: '0};
    end else if (ce) begin
      cur_ff <= nxt_ff;
    end
  end

  assign prdata = cur_ff.prdata;
  assign pready = cur_ff.pready;
  assign pslverr = cur_ff.pslverr;
  assign rx_ready = cur_ff.rx_ready;
  assign res_ready = cur_ff.res_ready;
  assign rd_idx = cur_ff.idx;
  assign tx_valid = cur_ff.tx_valid;
  assign tx_char = cur_ff.tx_char;
  assign tx_to232 = cur_ff.t232;
  assign tx_to485 = cur_ff.t485;
endmodule : serial_protocol_option_handler

// ---- testbench/option_checker_assertions.sv ----
// Port checks for the option handler, bound to its top module.
`timescale 1ns/1ns
module option_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_char,
  input wire logic        tx_to232,
  input wire logic        tx_to485,
  input wire logic        tx_ready
);
  // ---------------
  // Properties
  // ---------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_answer_next: assert property (psel && penable && !pready |=> pready)
    else $error("Access phase not answered in the next cycle.");
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("Ready held past one cycle.");
  a_slverr_map: assert property (pready |->
      pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("Error response does not match the address.");
  a_slverr_pair: assert property (pslverr |-> pready)
    else $error("Error response without ready.");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_char) && $stable(tx_to485))
    else $error("Transmit character changed while stalled.");
  a_all_232: assert property (tx_valid |-> tx_to232)
    else $error("Character not sent on the RS-232 port.");
  a_no_tilde: assert property (tx_valid && tx_to485 |-> tx_char != 8'h7e)
    else $error("Tilde forwarded onto the RS-485 port.");
  a_nak_code: assert property (tx_valid && tx_ready && tx_char == 8'h3f |->
      ##[1:8] (tx_valid && tx_char inside {[8'h31:8'h39]}))
    else $error("Negative acknowledge without an error code.");
  c_on_485: cover property (tx_valid && tx_ready && tx_to485);
  c_queued: cover property (tx_valid && tx_ready && tx_char == 8'h2a);
  c_unmapped: cover property (pready && pslverr);
endmodule : option_checker
bind serial_protocol_option_handler option_checker option_checker_i (.pclk, .presetn, .psel,
  .penable, .paddr, .pready, .pslverr, .tx_valid, .tx_char, .tx_to232, .tx_to485, .tx_ready);

// ---- testbench/tx_sink.sv ----
// Stalling transmit sink that logs characters per port, carriage return as a bar.
`timescale 1ns/1ns
module tx_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       tx_to232,
  input  wire logic       tx_to485,
  output logic            tx_ready
);
  logic [2:0] cnt_ff;
  string      s232;
  string      s485;
  string      c;
  // ---------------
  // Sink
  // ---------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 3'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_ff   <= cnt_ff + 3'h1;
      tx_ready <= (cnt_ff < 3'h5);
      if (tx_valid && tx_ready) begin
        c = string'(tx_char);
        if (tx_char == 8'h0d) c = "|";
        if (tx_to232) s232 = {s232, c};
        if (tx_to485) s485 = {s485, c};
      end
    end
  end
endmodule : tx_sink

// ---- testbench/serial_protocol_option_handler_bench.sv ----
// Self-checking bench for the option handler.
`timescale 1ns/1ns
module serial_protocol_option_handler_bench;
  import proto_pkg::*;
  typedef struct {
    logic [5:0]  pr;
    logic        p;
    string       cmd;
    res_kind_t   k;
    logic [3:0]  e;
    logic [15:0] l;
    logic [31:0] v;
    logic [23:0] r;
    logic [7:0]  c;
    string       o232;
    string       o485;
  } row_t;
  logic        pclk, presetn, ce, psel, penable, pwrite, rx_valid, rx_port, rx_last, errv;
  logic        res_valid, pready, pslverr, rx_ready, res_ready, tx_valid, tx_to232, tx_to485;
  logic        tx_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, res_value, rd_data, rdv;
  logic [7:0]  rx_char, res_count, tx_char;
  logic [3:0]  res_err;
  logic [15:0] res_letters;
  logic [23:0] res_reg;
  logic [6:0]  rd_idx;
  res_kind_t   res_kind;
  int          n_fail, total_checks;
  row_t        rows[16];
  // ---------------
  // Harness
  // ---------------
  serial_protocol_option_handler serial_protocol_option_handler_i (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_valid, .rx_char, .rx_port,
    .rx_last, .rx_ready, .res_valid, .res_kind, .res_err, .res_letters, .res_value, .res_reg,
    .res_count, .res_ready, .rd_idx, .rd_data, .tx_valid, .tx_char, .tx_to232, .tx_to485, .tx_ready);
  tx_sink tx_sink_i (.pclk, .presetn, .tx_valid, .tx_char, .tx_to232, .tx_to485, .tx_ready);
  assign rd_data = 32'(rd_idx) * 32'h0a;
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    #(20 * 30000);
    n_fail++;
    end_sim();
  end
  task automatic chkv(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chkv
  task automatic chks(input string nm, input string got, input string exp);
    total_checks++;
    if (got != exp) begin
      n_fail++;
      $display("MISMATCH %s expected %s seen %s", nm, exp, got);
    end
  endtask : chks
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) n_fail++;
    rdv  = prdata;
    errv = pslverr;
    psel    <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic run(input row_t r);
    int n;
    apb(1, 12'h000, 32'(r.pr));
    tx_sink_i.s232 = "";
    tx_sink_i.s485 = "";
    for (int i = 0; i < r.cmd.len(); i++) begin
      rx_valid <= 1;
      rx_char  <= r.cmd[i];
      rx_port  <= r.p;
      rx_last  <= (i == r.cmd.len() - 1);
      n = 0;
      do @(posedge pclk); while (rx_ready !== 1'b1 && ++n < 200);
      if (n >= 200) n_fail++;
    end
    rx_valid    <= 0;
    res_valid   <= 1;
    res_kind    <= r.k;
    res_err     <= r.e;
    res_letters <= r.l;
    res_value   <= r.v;
    res_reg     <= r.r;
    res_count   <= r.c;
    n = 0;
    do @(posedge pclk); while (res_ready !== 1'b1 && ++n < 200);
    if (n >= 200) n_fail++;
    res_valid <= 0;
    n = 0;
    do apb(0, 12'h008, 0); while ((rdv[3:0] !== 4'h0 || tx_valid !== 1'b0) && ++n < 200);
    if (n >= 200) n_fail++;
    chks("tx232", tx_sink_i.s232, r.o232);
    chks("tx485", tx_sink_i.s485, r.o485);
    $display("test %s done", r.cmd);
  endtask : run
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  // ---------------
  // Tests
  // ---------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, rx_valid, rx_char, rx_port, rx_last} = 0;
    {res_valid, res_err, res_letters, res_value, res_reg, res_count} = 0;
    res_kind = RK_DONE;
    ce = 1;
    rows = '{
      '{6'h04, 0, "DI8000", RK_DONE, 0, 0, 0, 0, 0, "%|", ""},
      '{6'h04, 0, "1DI8000", RK_DONE, 0, 0, 0, 0, 0, "1DI8000|1%|", "1%|"},
      '{6'h04, 1, "1AC10", RK_QUEUED, 0, 0, 0, 0, 0, "1AC10|1*|", "1*|"},
      '{6'h04, 0, "VE200", RK_NACK, 4'h5, 0, 0, 0, 0, "?5|", ""},
      '{6'h04, 0, "1VE200", RK_NACK, 4'he, 0, 0, 0, 0, "1VE200|1?14|", "1?14|"},
      '{6'h01, 0, "DI8000", RK_DONE, 0, 0, 0, 0, 0, "", ""},
      '{6'h01, 0, "DI", RK_DATA, 0, "DI", 32'h1f40, 0, 0, "DI=8000|", ""},
      '{6'h02, 0, "VE", RK_DATA, 0, "VE", 32'h32, 0, 0, "1VE=50|", ""},
      '{6'h09, 1, "DI", RK_DATA, 0, "DI", 0, 0, 0, "DI=0|", "DI=0|"},
      '{6'h14, 0, "~2DI8000", RK_SKIP, 0, 0, 0, 0, 0, "2DI8000|", "2DI8000|"},
      '{6'h10, 1, "1DI8000", RK_DONE, 0, 0, 0, 0, 0, "1DI8000|", ""},
      '{6'h24, 0, "RL017", RK_LOAD, 0, "RL", 0, "017", 0, "RLA=170|", ""},
      '{6'h24, 0, "RU0174", RK_UPLOAD, 0, "RU", 0, "017", 8'h04,
        "RUA=170|RUB=180|RUC=190|RUD=200|", ""},
      '{6'h24, 0, "RL074", RK_LOAD, 0, "RL", 0, "074", 0, "RLz=740|", ""},
      '{6'h24, 0, "RL075", RK_LOAD, 0, "RL", 0, "075", 0, "?5|", ""},
      '{6'h01, 0, "RLA", RK_LOAD, 0, "RL", 0, 24'h41, 0, "RLA=170|", ""}
    };
    repeat (10) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h000, 0);
    chkv("proto", rdv, 32'h01);
    apb(0, 12'h004, 0);
    chkv("addr", rdv, 32'h31);
    foreach (rows[i]) run(rows[i]);
    apb(1, 12'h000, 32'hffffffe4);
    apb(0, 12'h000, 0);
    chkv("proto36", rdv, 32'h24);
    apb(1, 12'h000, 0);
    apb(0, 12'h000, 0);
    chkv("proto0", rdv, 32'h01);
    apb(1, 12'h00c, 32'h05);
    chkv("wr_err", 32'(errv), 32'h1);
    apb(0, 12'h00c, 0);
    chkv("unmapped", rdv, 32'h0);
    apb(1, 12'h004, 32'h32);
    run('{6'h04, 0, "2DI8000", RK_DONE, 0, 0, 0, 0, 0, "2DI8000|2%|", "2%|"});
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h004, 0);
    chkv("addr_rst", rdv, 32'h31);
    apb(0, 12'h000, 0);
    chkv("proto_rst", rdv, 32'h01);
    $display("register tests done");
    end_sim();
  end
endmodule : serial_protocol_option_handler_bench
